/* rtl/dimmer_pkg.sv */
// constants and types shared by the pulse-count dimmer logic
package dimmer_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam real         SHUTDOWN_LOW_MS = 1.5;
  localparam real         GLITCH_LOW_US   = 0.2;
  // least times round up
  localparam int unsigned SHUTDOWN_CYCLES =
    int'($ceil(SHUTDOWN_LOW_MS * CLK_HZ / 1000.0));
  localparam int unsigned GLITCH_CYCLES_R =
    int'($ceil(GLITCH_LOW_US * CLK_HZ / 1_000_000.0));
  localparam int unsigned GLITCH_CYCLES   =
    (GLITCH_CYCLES_R < 1) ? 1 : GLITCH_CYCLES_R;

  localparam int          CNT_W = 17;
  localparam logic [CNT_W-1:0] CNT_ZERO = 17'h00000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 17'h00001;

  // ==========================================================
  // gain steps: step 0 is full scale (132), each step halves
  localparam int          STEP_W    = 3;
  localparam logic [STEP_W-1:0] STEP_FULL = 3'h0;
  localparam logic [STEP_W-1:0] STEP_LAST = 3'h5;
  localparam logic [STEP_W-1:0] STEP_ONE  = 3'h1;
  localparam int          CH_N      = 4;

  // gain codes in eighths of a unit: 132 x 8 = 1056
  localparam int          GAIN_W = 11;
  localparam logic [GAIN_W-1:0] GAIN_FULL_X8 = 11'h420;

  // ==========================================================
  // pump modes; the step-up request is analog-side, the mode register steps here
  typedef enum logic [1:0] {
    PUMP_1X, PUMP_1P33X, PUMP_1P5X, PUMP_2X
  } pump_mode_t;

  typedef enum logic [1:0] {
    ST_SHUTDOWN, ST_ACTIVE, ST_THERMAL
  } run_state_t;

endpackage : dimmer_pkg

/* rtl/pulse_count_led_dimmer.sv */
// enable/dim pulse counter, gain select and protection control
`timescale 1ns/1ps

// ==========================================================
// overview
// the host pin is both enable and dimming strobe. the first
// accepted rise out of shutdown turns the driver on at full
// gain; every later rise in active after a long-enough low steps the
// gain down one halving, wrapping after the last step.
// a low that lasts the shutdown count drops the driver to
// shutdown and clears the step, so the next enable is full.
// the analog senses arrive as raw levels; each one passes
// three flops and is taken only when the last two agree, so
// a single metastable sample can never move the state.
// the price is about four cycles of latency on every sense,
// far below any time the host or the analog side cares about.
// the pump is held in 1x from one cycle after the outputs go off, so a
// restart out of shutdown or thermal always begins at 1x.
// limitation: the glitch filter measures the low time after
// synchronisation, so it is exact only to one clock cycle.

module pulse_count_led_dimmer
  import dimmer_pkg::*;
(
  // clock, reset, enable
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              clk_en,
  // host pin
  input  wire logic              enable_dim_input,
  // analog sense inputs (asynchronous levels)
  input  wire logic [CH_N-1:0]   channel_open,
  input  wire logic              overvoltage,
  input  wire logic              over_temp,
  input  wire logic              temp_recovered,
  input  wire logic              mode_step_up,
  // outputs
  output logic                   driver_enabled,
  output logic [STEP_W-1:0]      gain_step,
  output logic [GAIN_W-1:0]      gain_x8,
  output logic [CH_N-1:0]        channel_regulate,
  output pump_mode_t             pump_mode,
  output logic                   mode_restart
);

  // ==========================================================
  // state record
  typedef struct packed {
    logic [2:0]        pin_sync;
    logic              pin;
    logic [CH_N-1:0]   open_s1, open_s2, open_s3, open_q;
    logic [2:0]        ov_sync, ot_sync, rec_sync, up_sync;
    logic              ov, ot, rec, up, up_prev;
    logic [CNT_W-1:0]  low_cnt;
    logic              enabled;
    run_state_t        run;
    logic [STEP_W-1:0] step;
    pump_mode_t        mode;
    logic              restart;
    logic [GAIN_W-1:0] gain;
    logic [CH_N-1:0]   regulate;
  } state_t;

  state_t cur;
  state_t next_cur;

  // ==========================================================
  // helpers
  function automatic logic [GAIN_W-1:0] gain_of(
    input logic [STEP_W-1:0] s);
    gain_of = GAIN_FULL_X8 >> s;
  endfunction : gain_of

  // a change counts once stages two and three agree
  function automatic logic agree(input logic [2:0] sh, input logic old);
    agree = (sh[1] == sh[2]) ? sh[2] : old;
  endfunction : agree

  // true in the only state where current may flow
  function automatic logic is_on(input run_state_t r);
    is_on = (r == ST_ACTIVE);
  endfunction : is_on

  // low-time counter has reached the shutdown count
  function automatic logic long_low(input logic [CNT_W-1:0] c);
    long_low = (c == SHUTDOWN_CYCLES[CNT_W-1:0]);
  endfunction : long_low

  // ==========================================================
  // next state
  always_comb begin
    logic pin_new;
    logic rise;
    pin_new  = 1'b0;
    rise     = 1'b0;
    next_cur = cur;
    next_cur.pin_sync = {cur.pin_sync[1:0], enable_dim_input};
    next_cur.ov_sync  = {cur.ov_sync[1:0], overvoltage};
    next_cur.ot_sync  = {cur.ot_sync[1:0], over_temp};
    next_cur.rec_sync = {cur.rec_sync[1:0], temp_recovered};
    next_cur.up_sync  = {cur.up_sync[1:0], mode_step_up};
    next_cur.open_s1  = channel_open;
    next_cur.open_s2  = cur.open_s1;
    next_cur.open_s3  = cur.open_s2;
    for (int i = 0; i < CH_N; i++) begin
      if (cur.open_s2[i] == cur.open_s3[i]) begin
        next_cur.open_q[i] = cur.open_s3[i];
      end
    end
    next_cur.ov  = agree(cur.ov_sync, cur.ov);
    next_cur.ot  = agree(cur.ot_sync, cur.ot);
    next_cur.rec = agree(cur.rec_sync, cur.rec);
    next_cur.up  = agree(cur.up_sync, cur.up);
    next_cur.up_prev = cur.up;
    pin_new = agree(cur.pin_sync, cur.pin);
    next_cur.pin = pin_new;
    rise = pin_new & ~cur.pin;

    // low-time counter saturates at the shutdown count
    if (pin_new) begin
      next_cur.low_cnt = CNT_ZERO;
    end else if (!long_low(cur.low_cnt)) begin
      next_cur.low_cnt = cur.low_cnt + CNT_ONE;
    end
    // restart is cleared each cycle unless set, so it stays high while overvoltage holds in active, unless all channels are open
    next_cur.restart = 1'b0;

    unique case (cur.run)
      ST_SHUTDOWN: begin
        next_cur.step = STEP_FULL;
        // pump idles in 1x while off
        next_cur.mode = PUMP_1X;
        if (rise) begin
          // a hot die goes straight to thermal, never lit
          next_cur.run  = cur.ot ? ST_THERMAL
                        : ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (cur.ot) begin
          next_cur.run = ST_THERMAL;
        end else if (long_low(cur.low_cnt)) begin
          next_cur.run  = ST_SHUTDOWN;
          next_cur.step = STEP_FULL;
        end else if (rise &&
                     cur.low_cnt >= GLITCH_CYCLES[CNT_W-1:0]) begin
          // short lows are glitches
          next_cur.step = (cur.step == STEP_LAST) ? STEP_FULL
                        : cur.step + STEP_ONE;
        end
        // pump mode control
        if (&cur.open_q) begin
          next_cur.mode = PUMP_1X;
        end else if (cur.ov) begin
          next_cur.mode    = PUMP_1X;
          next_cur.restart = 1'b1;
        end else if (cur.up && !cur.up_prev && cur.mode != PUMP_2X) begin
          next_cur.mode = pump_mode_t'(cur.mode + 2'h1);
        end
      end
      ST_THERMAL: begin
        // outputs off until the cooled indication
        next_cur.mode = PUMP_1X;
        if (cur.rec && !cur.ot) begin
          next_cur.run  = ST_ACTIVE;
        end
        // a long low still drops to shutdown while hot
        if (long_low(cur.low_cnt)) begin
          next_cur.run  = ST_SHUTDOWN;
          next_cur.step = STEP_FULL;
        end
      end
      default: next_cur.run = ST_SHUTDOWN;
    endcase

    // open channels never regulate
    next_cur.regulate = is_on(next_cur.run)
                      ? ~next_cur.open_q : {CH_N{1'b0}};
    next_cur.gain = is_on(next_cur.run)
                  ? gain_of(next_cur.step) : 11'h000;
    // enable is its own flop so the output never glitches
    next_cur.enabled  = is_on(next_cur.run);
  end

  // ==========================================================
  // registers; clock enable freezes everything
  // reset lands in shutdown with the pump parked in 1x, and
  // every sense flop cleared so no false edge follows release
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cur      <= '0;
      cur.run  <= ST_SHUTDOWN;
      cur.mode <= PUMP_1X;
    end else if (clk_en) begin
      cur <= next_cur;
    end
  end

  // outputs straight from flops; no decode after the state
  // register, so downstream analog never sees a decode hazard
  assign driver_enabled   = cur.enabled;
  assign gain_step        = cur.step;
  assign gain_x8          = cur.gain;
  assign channel_regulate = cur.regulate;
  assign pump_mode        = cur.mode;
  assign mode_restart     = cur.restart;

endmodule : pulse_count_led_dimmer

/* tb/dimmer_checker.sv */
// port assertions for the pulse-count dimmer
`timescale 1ns/1ps
module dimmer_checker
  import dimmer_pkg::*;
(
  // clock, reset and inputs
  input wire logic              core_clk, rstn, enable_dim_input,
  input wire logic [CH_N-1:0]   channel_open,
  input wire logic              overvoltage, over_temp,
  // outputs under watch
  input wire logic              driver_enabled, mode_restart,
  input wire logic [STEP_W-1:0] gain_step,
  input wire logic [GAIN_W-1:0] gain_x8,
  input wire logic [CH_N-1:0]   channel_regulate,
  input wire pump_mode_t        pump_mode
);
  // ==========================================================
  // one domain; sync latency of analog senses is under six cycles
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_gain_map: assert property (
    (driver_enabled && $stable(gain_step))[*2]
    |-> gain_x8 == (GAIN_FULL_X8 >> gain_step)) else $error("bad gain");
  a_step_wrap: assert property (
    $changed(gain_step) && driver_enabled && $past(driver_enabled)
    |-> gain_step == (($past(gain_step) == STEP_LAST) ? STEP_FULL
        : $past(gain_step) + STEP_ONE)) else $error("bad step");
  a_step_range: assert property (
    gain_step <= STEP_LAST) else $error("step range");
  a_high_hold: assert property (
    (enable_dim_input && driver_enabled)[*8] |=> $stable(gain_step))
    else $error("step w/o edge");
  a_off_zero: assert property (
    (!driver_enabled)[*2] |-> gain_x8 == 11'h000
    && channel_regulate == 4'h0) else $error("current when off");
  a_open_noreg: assert property (
    $stable(channel_open)[*6] |-> (channel_regulate & channel_open)
    == 4'h0) else $error("open regulated");
  a_all_open: assert property (
    (channel_open == 4'hf)[*6] |-> pump_mode == PUMP_1X)
    else $error("all open not 1x");
  a_ov_reset: assert property (
    (overvoltage && driver_enabled)[*6] |-> pump_mode == PUMP_1X
    && mode_restart) else $error("no restart");
  a_hot_off: assert property (
    over_temp[*6] |-> !driver_enabled) else $error("hot but on");
endmodule : dimmer_checker
bind pulse_count_led_dimmer dimmer_checker i_chk (.*);

/* tb/host_pin_model.sv */
// host pin driver: holds the pin low for a commanded count
`timescale 1ns/1ps
module host_pin_model (
  // control from the bench
  input  wire logic        core_clk,
  input  wire logic        en,
  input  wire logic        go,
  input  wire logic [16:0] low_len,
  // pin and status
  output logic             pin,
  output logic             busy
);
  logic [16:0] cnt;
  // ==========================================================
  // low count; the bench asks 8..200 cycles for dimming lows
  // a released enable clears the count, so no init is needed
  always_ff @(posedge core_clk) begin
    if (!en) cnt <= 17'h0;
    else if (go) cnt <= low_len;
    else if (busy) cnt <= cnt - 17'h1;
  end
  assign busy = cnt != 17'h0;
  assign pin  = en && !busy;
endmodule : host_pin_model

/* tb/pulse_count_led_dimmer_tb_top.sv */
// self-checking bench for the pulse-count dimmer
`timescale 1ns/1ps
module pulse_count_led_dimmer_tb_top;
  import dimmer_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic core_clk = 0, rstn = 0, clk_en = 1, en = 0, go = 0;
  logic overvoltage = 0, over_temp = 0, temp_recovered = 0;
  logic mode_step_up = 0, pin, busy, driver_enabled, mode_restart;
  logic [16:0] low_len = 17'h8;
  logic [3:0]  channel_open = 4'h0, channel_regulate;
  logic [2:0]  gain_step, k;
  logic [10:0] gain_x8;
  pump_mode_t  pump_mode;
  int num_errors = 0, n_compared = 0;
  always #12.5 core_clk = ~core_clk;
  host_pin_model i_host (.core_clk, .en, .go, .low_len, .pin, .busy);
  pulse_count_led_dimmer i_dut (.core_clk, .rstn, .clk_en,
    .enable_dim_input(pin), .channel_open, .overvoltage, .over_temp,
    .temp_recovered, .mode_step_up, .driver_enabled, .gain_step,
    .gain_x8, .channel_regulate, .pump_mode, .mode_restart);
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %0h got %0h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // one low pulse, then a high gap well over the minimum
  task automatic pulse(input logic [16:0] n);
    int i;
    @(posedge core_clk) go <= 1'b1;
    low_len <= n;
    @(posedge core_clk) go <= 1'b0;
    for (i = 0; i < 70000 && (busy || i < 1); i++) cyc(1);
    if (busy) begin
      num_errors++;
      complete_run();
    end
    cyc(40);
  endtask : pulse
  task automatic ups;
    repeat (2) begin
      mode_step_up <= 1'b1;
      cyc(8);
      mode_step_up <= 1'b0;
      cyc(8);
    end
  endtask : ups
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(36879));
    cyc(6);
    rstn <= 1'b1;
    en <= 1'b1;
    cyc(400);
    chk("enable", driver_enabled, 1);
    chk("full", gain_x8, 11'h420);
    for (int p = 1; p <= 7; p++) begin
      pulse(17'($urandom_range(8, 200)));
      k = 3'(p % 6);
      chk("step", gain_step, k);
      chk("gain", gain_x8, 11'h420 >> k);
    end
    pulse(17'h3);
    chk("glitch", gain_step, 3'h1);
    $display("test dimming done");
    channel_open <= 4'($urandom_range(1, 14));
    cyc(10);
    chk("reg", channel_regulate, channel_open ^ 4'hf);
    ups();
    channel_open <= 4'hf;
    cyc(10);
    chk("all open", pump_mode, PUMP_1X);
    channel_open <= 4'h0;
    ups();
    chk("stepped", pump_mode, PUMP_1P5X);
    overvoltage <= 1'b1;
    cyc(10);
    chk("ov mode", pump_mode, PUMP_1X);
    chk("restart", mode_restart, 1);
    overvoltage <= 1'b0;
    over_temp <= 1'b1;
    cyc(10);
    chk("hot", driver_enabled, 0);
    over_temp <= 1'b0;
    cyc(10);
    chk("no early", driver_enabled, 0);
    temp_recovered <= 1'b1;
    cyc(10);
    chk("cooled", driver_enabled, 1);
    chk("kept", gain_step, 3'h1);
    temp_recovered <= 1'b0;
    clk_en <= 1'b0;
    pulse(17'($urandom_range(8, 200)));
    clk_en <= 1'b1;
    cyc(10);
    chk("frozen", gain_step, 3'h1);
    $display("test protection done");
    en <= 1'b0;
    cyc(60100);
    chk("shutdown", driver_enabled, 0);
    en <= 1'b1;
    cyc(400);
    chk("restart step", gain_step, 3'h0);
    $display("test shutdown done");
    complete_run();
  end
endmodule : pulse_count_led_dimmer_tb_top
